// *** src/pit_pkg.sv ***
// constants for the peripheral interrupt and time-base block
package pit_pkg;
  // register indices on the plain register port
  localparam logic [2:0] PIT_REG_CTRL0 = 3'h0; // shared/touch flags+enables
  localparam logic [2:0] PIT_REG_CTRL1 = 3'h1; // eeprom/tick/serial
  localparam logic [2:0] PIT_REG_TIMER = 3'h2; // comparator flags+enables
  localparam logic [2:0] PIT_REG_CLKSEL = 3'h3; // time_base_clock_select
  localparam logic [2:0] PIT_REG_TBCTL = 3'h4; // time_base_control
  localparam logic [2:0] PIT_REG_VECTOR = 3'h5; // pending vector, read only
  // bit positions in ctrl0
  localparam int PIT_B_GIE = 0;
  localparam int PIT_B_TKE = 2;
  localparam int PIT_B_SHE = 3;
  localparam int PIT_B_TKF = 5;
  localparam int PIT_B_SHF = 6;
  // bit positions in ctrl1
  localparam int PIT_B_SIE = 0;
  localparam int PIT_B_TIE = 1;
  localparam int PIT_B_EPE = 2;
  localparam int PIT_B_SIF = 4;
  localparam int PIT_B_TIF = 5;
  localparam int PIT_B_EPF = 6;
  // bit positions in timer register
  localparam int PIT_B_PE = 0;
  localparam int PIT_B_AE = 1;
  localparam int PIT_B_PF = 4;
  localparam int PIT_B_AF = 5;
  // time_base_control fields
  localparam int PIT_B_RUN = 3;
  localparam int PIT_PERIOD_BASE = 8; // code n gives 2^(8+n)
  localparam logic [7:0] PIT_RESET_VAL = 8'h00;
  // prescaler clock selection codes
  localparam logic [1:0] PIT_CK_SYS = 2'h0;
  localparam logic [1:0] PIT_CK_SYS4 = 2'h1;
  localparam logic [1:0] PIT_CK_SUB = 2'h2;
  localparam logic [1:0] PIT_CK_HS = 2'h3;
  localparam int PIT_SYS4_DIV = 4;
  // vector codes, also the fixed priority order
  localparam logic [2:0] PIT_VEC_NONE = 3'h0;
  localparam logic [2:0] PIT_VEC_TOUCH = 3'h1;
  localparam logic [2:0] PIT_VEC_SHARED = 3'h2;
  localparam logic [2:0] PIT_VEC_TICK = 3'h3;
  localparam logic [2:0] PIT_VEC_SERIAL = 3'h4;
  localparam logic [2:0] PIT_VEC_EEPROM = 3'h5;
endpackage : pit_pkg

// *** src/pit_tick.sv ***
// time-base generator: clock select, run gate and power-of-two divider
`timescale 1ns/1ns
module pit_tick
  import pit_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sub_clk_s,
  input wire logic hs_clk_s,
  input wire logic [1:0] tick_clock_select,
  input wire logic tick_run,
  input wire logic [2:0] tick_period_select,
  output logic tick_overflow
);
  logic [1:0] sys4_cnt;
  logic sub_d;
  logic hs_d;
  logic presc_en;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] last_val;

  // ------------------------------------------------------------
  // prescaler clock enable
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys4_cnt <= 2'h0;
      sub_d <= 1'b0;
      hs_d <= 1'b0;
    end else begin
      sys4_cnt <= sys4_cnt + 2'h1;
      sub_d <= sub_clk_s;
      hs_d <= hs_clk_s;
    end
  end

  // rising edges of the synchronised slow clocks count as ticks
  always_comb begin
    case (tick_clock_select)
      PIT_CK_SYS: presc_en = 1'b1;
      PIT_CK_SYS4: presc_en = (sys4_cnt == 2'(PIT_SYS4_DIV - 1));
      PIT_CK_SUB: presc_en = sub_clk_s & ~sub_d;
      PIT_CK_HS: presc_en = hs_clk_s & ~hs_d;
      default: presc_en = 1'b0;
    endcase
  end

  // terminal count 2^(8+n)-1
  assign last_val = DIV_W'((32'h1 << (PIT_PERIOD_BASE +
                    int'(tick_period_select))) - 32'h1);

  // ------------------------------------------------------------
  // period divider
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      tick_overflow <= 1'b0;
    end else if (!tick_run) begin
      div_cnt <= '0;
      tick_overflow <= 1'b0;
    end else if (presc_en) begin
      tick_overflow <= (div_cnt >= last_val);
      div_cnt <= (div_cnt >= last_val) ? '0 : div_cnt + 1'b1;
    end else begin
      tick_overflow <= 1'b0;
    end
  end

  chk_tick_stopped_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    !tick_run |=> !tick_overflow)
    else $error("tick overflow while stopped");
endmodule : pit_tick

// *** src/pit_irq.sv ***
// interrupt request flags, enables, vector arbitration and time base
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
module pit_irq
  import pit_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic touch_overflow,
  input wire logic serial_event,
  input wire logic eeprom_write_done,
  input wire logic cmp_a_match,
  input wire logic cmp_p_match,
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  input wire logic sub_clk,
  input wire logic hs_clk,
  output logic irq_req,
  output logic [2:0] irq_vector,
  output logic wake_up
);
  logic rst_m;
  logic rst_n;
  logic sub_m;
  logic sub_s;
  logic hs_m;
  logic hs_s;
  logic global_irq_enable;
  logic touch_irq_enable;
  logic touch_irq_flag;
  logic shared_irq_enable;
  logic shared_irq_flag;
  logic serial_irq_enable;
  logic serial_irq_flag;
  logic tick_irq_enable;
  logic tick_irq_flag;
  logic eeprom_irq_enable;
  logic eeprom_irq_flag;
  logic cmp_a_enable;
  logic cmp_a_flag;
  logic cmp_p_enable;
  logic cmp_p_flag;
  logic [1:0] tick_clock_select;
  logic tick_run;
  logic [2:0] tick_period_select;
  logic tick_overflow;
  logic [7:0] ctrl0_val;
  logic [7:0] ctrl1_val;
  logic [7:0] timer_val;
  logic [7:0] flags_now;
  logic [7:0] flags_old;
  logic [2:0] next_vector;
  logic serve;
  logic wr0;
  logic wr1;
  logic wrt;

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // sub and high-speed clocks come from other oscillators
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sub_m <= 1'b0;
      sub_s <= 1'b0;
      hs_m <= 1'b0;
      hs_s <= 1'b0;
    end else begin
      sub_m <= sub_clk;
      sub_s <= sub_m;
      hs_m <= hs_clk;
      hs_s <= hs_m;
    end
  end

  // ------------------------------------------------------------
  // time base
  // ------------------------------------------------------------
  pit_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .sub_clk_s(sub_s),
    .hs_clk_s(hs_s),
    .tick_clock_select(tick_clock_select),
    .tick_run(tick_run),
    .tick_period_select(tick_period_select),
    .tick_overflow(tick_overflow)
  );

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  // fixed order: touch, shared, tick, serial, eeprom
  always_comb begin
    next_vector = PIT_VEC_NONE;
    if (global_irq_enable && !stack_full) begin
      if (touch_irq_enable && touch_irq_flag) begin
        next_vector = PIT_VEC_TOUCH;
      end else if (shared_irq_enable && shared_irq_flag) begin
        next_vector = PIT_VEC_SHARED;
      end else if (tick_irq_enable && tick_irq_flag) begin
        next_vector = PIT_VEC_TICK;
      end else if (serial_irq_enable && serial_irq_flag) begin
        next_vector = PIT_VEC_SERIAL;
      end else if (eeprom_irq_enable && eeprom_irq_flag) begin
        next_vector = PIT_VEC_EEPROM;
      end
    end
  end

  // acknowledge only counts for a vector currently offered
  assign serve = irq_ack && irq_req && (irq_vector == next_vector);
  assign wr0 = reg_write && (reg_addr == PIT_REG_CTRL0);
  assign wr1 = reg_write && (reg_addr == PIT_REG_CTRL1);
  assign wrt = reg_write && (reg_addr == PIT_REG_TIMER);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_vector <= PIT_VEC_NONE;
    end else if (serve) begin
      irq_req <= 1'b0; // one vector per acknowledge
      irq_vector <= PIT_VEC_NONE;
    end else begin
      irq_req <= (next_vector != PIT_VEC_NONE);
      irq_vector <= next_vector;
    end
  end

  // ------------------------------------------------------------
  // global enable
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable <= 1'b0;
    end else if (serve) begin
      global_irq_enable <= 1'b0;
    end else if (return_from_interrupt) begin
      global_irq_enable <= 1'b1;
    end else if (wr0) begin
      global_irq_enable <= reg_wdata[PIT_B_GIE];
    end
  end

  // ------------------------------------------------------------
  // enables
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      touch_irq_enable <= 1'b0;
      shared_irq_enable <= 1'b0;
      serial_irq_enable <= 1'b0;
      tick_irq_enable <= 1'b0;
      eeprom_irq_enable <= 1'b0;
      cmp_a_enable <= 1'b0;
      cmp_p_enable <= 1'b0;
      tick_clock_select <= 2'h0;
      tick_run <= 1'b0;
      tick_period_select <= 3'h0;
    end else begin
      if (wr0) begin
        touch_irq_enable <= reg_wdata[PIT_B_TKE];
        shared_irq_enable <= reg_wdata[PIT_B_SHE];
      end
      if (wr1) begin
        serial_irq_enable <= reg_wdata[PIT_B_SIE];
        tick_irq_enable <= reg_wdata[PIT_B_TIE];
        eeprom_irq_enable <= reg_wdata[PIT_B_EPE];
      end
      if (wrt) begin
        cmp_a_enable <= reg_wdata[PIT_B_AE];
        cmp_p_enable <= reg_wdata[PIT_B_PE];
      end
      if (reg_write && reg_addr == PIT_REG_CLKSEL) begin
        tick_clock_select <= reg_wdata[1:0];
      end
      if (reg_write && reg_addr == PIT_REG_TBCTL) begin
        tick_run <= reg_wdata[PIT_B_RUN];
        tick_period_select <= reg_wdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // request flags: event set wins over any clear
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      touch_irq_flag <= 1'b0;
      shared_irq_flag <= 1'b0;
    end else begin
      if (touch_overflow) begin
        touch_irq_flag <= 1'b1;
      end else if (serve && irq_vector == PIT_VEC_TOUCH) begin
        touch_irq_flag <= 1'b0;
      end else if (wr0) begin
        touch_irq_flag <= reg_wdata[PIT_B_TKF];
      end
      // shared flag is set by a match of a member whose enable is on
      if ((cmp_a_match && cmp_a_enable) || (cmp_p_match && cmp_p_enable)) begin
        shared_irq_flag <= 1'b1;
      end else if (serve && irq_vector == PIT_VEC_SHARED) begin
        shared_irq_flag <= 1'b0;
      end else if (wr0) begin
        shared_irq_flag <= reg_wdata[PIT_B_SHF];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_irq_flag <= 1'b0;
      serial_irq_flag <= 1'b0;
      eeprom_irq_flag <= 1'b0;
    end else begin
      if (tick_overflow) begin
        tick_irq_flag <= 1'b1;
      end else if (serve && irq_vector == PIT_VEC_TICK) begin
        tick_irq_flag <= 1'b0;
      end else if (wr1) begin
        tick_irq_flag <= reg_wdata[PIT_B_TIF];
      end
      if (serial_event) begin
        serial_irq_flag <= 1'b1;
      end else if (serve && irq_vector == PIT_VEC_SERIAL) begin
        serial_irq_flag <= 1'b0;
      end else if (wr1) begin
        serial_irq_flag <= reg_wdata[PIT_B_SIF];
      end
      if (eeprom_write_done) begin
        eeprom_irq_flag <= 1'b1;
      end else if (serve && irq_vector == PIT_VEC_EEPROM) begin
        eeprom_irq_flag <= 1'b0;
      end else if (wr1) begin
        eeprom_irq_flag <= reg_wdata[PIT_B_EPF];
      end
    end
  end

  // member flags are cleared only by software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_flag <= 1'b0;
      cmp_p_flag <= 1'b0;
    end else begin
      if (cmp_a_match) begin
        cmp_a_flag <= 1'b1;
      end else if (wrt) begin
        cmp_a_flag <= reg_wdata[PIT_B_AF];
      end
      if (cmp_p_match) begin
        cmp_p_flag <= 1'b1;
      end else if (wrt) begin
        cmp_p_flag <= reg_wdata[PIT_B_PF];
      end
    end
  end

  // ------------------------------------------------------------
  // wake-up on any rising flag, enables ignored
  // ------------------------------------------------------------
  assign flags_now = {1'b0, touch_irq_flag, shared_irq_flag, tick_irq_flag,
                      serial_irq_flag, eeprom_irq_flag, cmp_a_flag,
                      cmp_p_flag};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_old <= 8'h00;
      wake_up <= 1'b0;
    end else begin
      flags_old <= flags_now;
      wake_up <= |(flags_now & ~flags_old);
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  assign ctrl0_val = 8'(({7'h0, shared_irq_flag} << PIT_B_SHF) |
                     ({7'h0, touch_irq_flag} << PIT_B_TKF) |
                     ({7'h0, shared_irq_enable} << PIT_B_SHE) |
                     ({7'h0, touch_irq_enable} << PIT_B_TKE) |
                     ({7'h0, global_irq_enable} << PIT_B_GIE));
  assign ctrl1_val = 8'(({7'h0, eeprom_irq_flag} << PIT_B_EPF) |
                     ({7'h0, tick_irq_flag} << PIT_B_TIF) |
                     ({7'h0, serial_irq_flag} << PIT_B_SIF) |
                     ({7'h0, eeprom_irq_enable} << PIT_B_EPE) |
                     ({7'h0, tick_irq_enable} << PIT_B_TIE) |
                     ({7'h0, serial_irq_enable} << PIT_B_SIE));
  assign timer_val = 8'(({7'h0, cmp_a_flag} << PIT_B_AF) |
                     ({7'h0, cmp_p_flag} << PIT_B_PF) |
                     ({7'h0, cmp_a_enable} << PIT_B_AE) |
                     ({7'h0, cmp_p_enable} << PIT_B_PE));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= PIT_RESET_VAL;
    end else if (reg_read) begin
      case (reg_addr)
        PIT_REG_CTRL0: reg_rdata <= ctrl0_val;
        PIT_REG_CTRL1: reg_rdata <= ctrl1_val;
        PIT_REG_TIMER: reg_rdata <= timer_val;
        PIT_REG_CLKSEL: reg_rdata <= {6'h00, tick_clock_select};
        PIT_REG_TBCTL: reg_rdata <= {4'h0, tick_run, tick_period_select};
        PIT_REG_VECTOR: reg_rdata <= {5'h00, irq_vector};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_full_stack_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    stack_full |=> !irq_req)
    else $error("vector offered with full stack");
  chk_serve_clears_gie: assert property (@(posedge mclk) disable iff (!rst_n)
    serve && !return_from_interrupt |=> !global_irq_enable)
    else $error("global enable kept after service");
  chk_return_from_interrupt_sets_gie: assert property (@(posedge mclk) disable iff (!rst_n)
    return_from_interrupt && !serve |=> global_irq_enable)
    else $error("return did not restore global enable");
  chk_touch_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    touch_overflow |=> touch_irq_flag)
    else $error("touch flag not set");
  chk_tick_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    tick_overflow |=> tick_irq_flag)
    else $error("tick flag not set");
  chk_shared_keeps_member: assert property (@(posedge mclk)
    disable iff (!rst_n)
    serve && irq_vector == PIT_VEC_SHARED && cmp_a_flag && !wrt
    |=> cmp_a_flag)
    else $error("member flag cleared by service");
  chk_wake_on_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(eeprom_irq_flag) |=> wake_up)
    else $error("no wake-up on rising flag");
  chk_vector_needs_gie: assert property (@(posedge mclk) disable iff (!rst_n)
    !global_irq_enable |=> !irq_req)
    else $error("vector with global enable off");
  chk_serial_flag_holds: assert property (@(posedge mclk)
    disable iff (!rst_n)
    serial_irq_flag && !serve && !wr1 |=> serial_irq_flag)
    else $error("serial flag lost");
endmodule : pit_irq

// *** testbench/pit_core_model.sv ***
// processor core model: takes offered vectors after a chosen delay
`timescale 1ns/1ns
module pit_core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic [2:0] irq_vector,
  input wire logic ack_on,
  input wire logic [3:0] ack_delay,
  output logic irq_ack,
  output logic [2:0] taken_vec,
  output logic [7:0] taken_cnt
);
  logic [3:0] wait_cnt;
  // one-cycle acknowledge, then restart the delay count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
      taken_vec <= 3'h0;
      taken_cnt <= 8'h00;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_req && ack_on && wait_cnt >= ack_delay) begin
      irq_ack <= 1'b1;
      taken_vec <= irq_vector;
      taken_cnt <= taken_cnt + 8'h01;
    end else if (irq_req && ack_on) begin
      wait_cnt <= wait_cnt + 4'h1; // slow core
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule : pit_core_model

// *** testbench/peripheral_irq_and_time_base_tb.sv ***
// self-checking bench for request flags, vectors and the time base
`timescale 1ns/1ns
module peripheral_irq_and_time_base_tb
  import pit_pkg::*;
;
  localparam logic [7:0] m_gie = 8'h01 << PIT_B_GIE;
  localparam logic [7:0] m_tke = 8'h01 << PIT_B_TKE;
  localparam logic [7:0] m_tkf = 8'h01 << PIT_B_TKF;
  localparam logic [7:0] m_she = 8'h01 << PIT_B_SHE;
  localparam logic [7:0] m_tie = 8'h01 << PIT_B_TIE;
  logic mclk = 1'b0, reset_n = 1'b0, sub_clk = 1'b0, hs_clk = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, stack_full = 1'b0;
  logic ret_pulse = 1'b0, ack_on = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [4:0] ev = 5'h00;
  logic [3:0] ack_delay = 4'h0;
  logic irq_req, irq_ack, wake_up;
  logic [2:0] irq_vector, taken_vec;
  logic [7:0] reg_rdata, taken_cnt, n;
  logic [2:0] prio [4] = '{PIT_VEC_TOUCH, PIT_VEC_SHARED,
                           PIT_VEC_SERIAL, PIT_VEC_EEPROM};
  int failures = 0;
  int check_count = 0;
  int wake_cnt = 0;
  int w0;

  // clocks: system, sub and high-speed, unrelated in phase
  always #4 mclk = ~mclk;
  always #42 sub_clk = ~sub_clk;
  always #13 hs_clk = ~hs_clk;
  // counts wake-up pulses
  always @(posedge mclk) if (wake_up === 1'b1) wake_cnt <= wake_cnt + 1;

  pit_irq dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .touch_overflow(ev[0]), .serial_event(ev[1]),
    .eeprom_write_done(ev[2]), .cmp_a_match(ev[3]), .cmp_p_match(ev[4]),
    .stack_full(stack_full), .irq_ack(irq_ack),
    .return_from_interrupt(ret_pulse), .sub_clk(sub_clk), .hs_clk(hs_clk),
    .irq_req(irq_req), .irq_vector(irq_vector), .wake_up(wake_up));
  pit_core_model core (.mclk(mclk), .rst_n(reset_n), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_on(ack_on), .ack_delay(ack_delay),
    .irq_ack(irq_ack), .taken_vec(taken_vec), .taken_cnt(taken_cnt));

  // ----------------------------------------
  // tasks and expectation functions
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_t(input string what, input longint exp,
                       input longint got, input longint tol);
    check_count++;
    if (got > exp + tol || got + tol < exp) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_t
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string what, input logic [2:0] a,
                        input logic [7:0] exp);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd_chk
  task automatic pulse(input logic [4:0] m, input logic r);
    @(posedge mclk);
    ev <= m;
    ret_pulse <= r;
    @(posedge mclk);
    ev <= 5'h00;
    ret_pulse <= 1'b0;
  endtask : pulse
  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : idle
  // bounded wait for a wake-up pulse or for a taken vector
  task automatic wait_ev(input logic wake, input logic [7:0] prev);
    int i;
    for (i = 0; i < 70000; i++) begin
      @(posedge mclk);
      #1;
      if (wake ? wake_up === 1'b1 : taken_cnt !== prev) break;
    end
    if (i == 70000) begin
      failures++;
      $display("[ERR] wait expected event seen none");
      give_verdict();
    end
  endtask : wait_ev
  task automatic clear_all();
    wr(PIT_REG_CTRL0, 8'h00);
    wr(PIT_REG_CTRL1, 8'h00);
    wr(PIT_REG_TIMER, 8'h00);
  endtask : clear_all
  function automatic logic [7:0] wmask(input int a);
    case (a)
      0: return 8'h6d;
      1: return 8'h77;
      2: return 8'h33;
      3: return 8'h03;
      4: return 8'h0f;
      default: return 8'h00;
    endcase
  endfunction : wmask
  function automatic logic [7:0] en0(input int s);
    return m_gie | ((s == 0) ? m_tke : 8'h00) | ((s > 2) ? m_she : 8'h00);
  endfunction : en0
  function automatic logic [7:0] en1(input int s);
    return (s == 1) ? 8'h01 << PIT_B_SIE : (s == 2) ? 8'h01 << PIT_B_EPE : 8'h00;
  endfunction : en1
  function automatic logic [7:0] ent(input int s);
    return (s == 3) ? 8'h01 << PIT_B_AE : (s == 4) ? 8'h01 << PIT_B_PE : 8'h00;
  endfunction : ent
  // one source raised, vectored, serviced and returned from
  task automatic serve(input int s);
    logic [2:0] v;
    v = (s == 0) ? PIT_VEC_TOUCH : (s == 1) ? PIT_VEC_SERIAL :
        (s == 2) ? PIT_VEC_EEPROM : PIT_VEC_SHARED;
    n = taken_cnt;
    wr(PIT_REG_CTRL0, en0(s));
    wr(PIT_REG_CTRL1, en1(s));
    wr(PIT_REG_TIMER, ent(s));
    pulse(5'h01 << s, 1'b0);
    wait_ev(1'b0, n);
    chk("vector", {5'h00, v}, {5'h00, taken_vec});
    rd_chk("ctrl0 served", PIT_REG_CTRL0, en0(s) & ~m_gie);
    rd_chk("ctrl1 served", PIT_REG_CTRL1, en1(s));
    rd_chk("members kept", PIT_REG_TIMER, ent(s) | (ent(s) << 4));
    pulse(5'h00, 1'b1);
    rd_chk("ctrl0 returned", PIT_REG_CTRL0, en0(s));
    clear_all();
  endtask : serve
  // measures the interval between two tick flag rises
  task automatic tb_run(input logic [1:0] sel, input logic [2:0] code);
    longint t0, per;
    per = longint'(1) << (PIT_PERIOD_BASE + code);
    per = per * ((sel == PIT_CK_SYS) ? 8 : (sel == PIT_CK_SYS4) ?
          8 * PIT_SYS4_DIV : (sel == PIT_CK_SUB) ? 84 : 26);
    wr(PIT_REG_CLKSEL, {6'h00, sel});
    wr(PIT_REG_TBCTL, {5'h01, code});
    wait_ev(1'b1, 8'h00);
    t0 = $time;
    wr(PIT_REG_CTRL1, 8'h00);
    wait_ev(1'b1, 8'h00);
    chk_t("tick period ns", per, $time - t0, sel[1] ? 8 : 0);
    wr(PIT_REG_TBCTL, 8'h00);
    wr(PIT_REG_CTRL1, 8'h00);
  endtask : tb_run

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(30416));
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 8; a++) begin
      rd_chk("reset value", 3'(a), PIT_RESET_VAL);
      wr(3'(a), 8'hff);
      rd_chk("written value", 3'(a), wmask(a));
      wr(3'(a), 8'h00);
    end
    clear_all();
    $display("done register map");
    ack_on <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      ack_delay <= 4'($urandom_range(0, 5));
      serve(k < 5 ? k : int'($urandom_range(0, 4)));
    end
    $display("done per-source service");
    n = taken_cnt;
    w0 = wake_cnt;
    wr(PIT_REG_CTRL0, m_tke);
    pulse(5'h01, 1'b0);
    idle(10);
    chk("wake count", 8'(w0 + 1), 8'(wake_cnt));
    chk("take count", n, taken_cnt);
    rd_chk("flag held", PIT_REG_CTRL0, m_tke | m_tkf);
    wr(PIT_REG_CTRL0, m_gie | m_tkf);
    idle(10);
    chk("take count", n, taken_cnt);
    @(posedge mclk);
    stack_full <= 1'b1;
    wr(PIT_REG_CTRL0, m_gie | m_tke | m_tkf);
    idle(10);
    chk("take count", n, taken_cnt);
    @(posedge mclk);
    stack_full <= 1'b0;
    wait_ev(1'b0, n);
    chk("vector", {5'h00, PIT_VEC_TOUCH}, {5'h00, taken_vec});
    clear_all();
    wr(PIT_REG_CTRL0, m_tkf);
    idle(4);
    w0 = wake_cnt;
    pulse(5'h01, 1'b0);
    idle(4);
    chk("wake count", 8'(w0), 8'(wake_cnt));
    clear_all();
    $display("done enables, stack and wake-up");
    wr(PIT_REG_CTRL0, m_gie | m_tke | m_she);
    wr(PIT_REG_CTRL1, (8'h01 << PIT_B_SIE) | (8'h01 << PIT_B_EPE));
    wr(PIT_REG_TIMER, (8'h01 << PIT_B_AE) | (8'h01 << PIT_B_PE));
    n = taken_cnt;
    pulse(5'h1f, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wait_ev(1'b0, n);
      n = taken_cnt;
      chk("priority vector", {5'h00, prio[k]}, {5'h00, taken_vec});
      pulse(5'h00, 1'b1);
    end
    idle(20);
    chk("extra take", n, taken_cnt);
    clear_all();
    $display("done priority");
    for (int k = 0; k < 9; k++) begin
      tb_run(k < 6 ? 2'h0 : 2'(k - 5), k < 6 ? 3'(k) : 3'h0);
    end
    wr(PIT_REG_CLKSEL, 8'h00);
    w0 = wake_cnt;
    idle(600);
    chk("wake count", 8'(w0), 8'(wake_cnt));
    wr(PIT_REG_CTRL1, m_tie);
    wr(PIT_REG_CTRL0, m_gie);
    n = taken_cnt;
    wr(PIT_REG_TBCTL, 8'h08);
    wait_ev(1'b0, n);
    wr(PIT_REG_TBCTL, 8'h00);
    chk("vector", {5'h00, PIT_VEC_TICK}, {5'h00, taken_vec});
    rd_chk("ctrl1 served", PIT_REG_CTRL1, m_tie);
    rd_chk("ctrl0 served", PIT_REG_CTRL0, 8'h00);
    $display("done time base");
    give_verdict();
  end
endmodule : peripheral_irq_and_time_base_tb
